// File: design/tft_port_pkg.sv
package tft_port_pkg;
	// Clock and pin widths.
	localparam int CLK_PERIOD_NS = 10;
	localparam int DATA_W = 18;
	localparam int DEFAULT_BUS_WIDTH = 18;
	localparam int CTL_W = 5;
	// Positions of the control lines within the control vector.
	localparam int CTL_WR = 0;
	localparam int CTL_RD = 1;
	localparam int CTL_CMD_DATA_SEL = 2;
	localparam int CTL_CS = 3;
	localparam int CTL_RST = 4;
	// Sequencer levels: reset high, select low, all strobes idle.
	localparam logic [CTL_W-1:0] CTL_SEQ_LEVELS = 5'h17;
	// Power-up timing.
	localparam int INIT_TIME_MS = 500;
	localparam int INIT_CYCLES = INIT_TIME_MS * 1_000_000 / CLK_PERIOD_NS;
	localparam int HOST_WAIT_MS = 1000;
	localparam int HOST_WAIT_CYCLES = HOST_WAIT_MS * 1_000_000 / CLK_PERIOD_NS;
	localparam int TIMER_W = 27;
	// Host strobe timing; the device samples pins through two flip-flops.
	localparam int SETUP_NS = 30;
	localparam int STROBE_NS = 80;
	localparam int HOLD_NS = 40;
	localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PHASE_W = 4;
	// Frame buffer geometry.
	localparam int FRAME_COLS = 640;
	localparam int FRAME_ROWS = 480;
	localparam int FRAME_BPP = 18;
	localparam int FRAME_PIXELS = FRAME_COLS * FRAME_ROWS;
	localparam int PIX_CNT_W = 19;
	// Power-up command list: bit 18 marks a command code.
	localparam int INIT_LEN = 4;
	localparam int INIT_IDX_W = 2;
	localparam logic [DATA_W:0] INIT_TABLE [INIT_LEN] = '{
		19'h40001, 19'h400e0, 19'h00001, 19'h40029
	};
	// Host command word: read flag, command flag, data.
	localparam int CMD_W = DATA_W + 2;
	localparam int CMD_READ_BIT = DATA_W + 1;
	localparam int CMD_IS_CMD_BIT = DATA_W;
	localparam int FIFO_DEPTH_DEF = 8;

	typedef enum logic [1:0] {
		SEQ_LOAD = 2'b00,
		SEQ_WAIT = 2'b01,
		SEQ_DONE = 2'b10
	} seq_state_t;

	typedef enum logic [2:0] {
		H_INIT = 3'b000,
		H_IDLE = 3'b001,
		H_SETUP = 3'b010,
		H_STROBE = 3'b011,
		H_HOLD = 3'b100
	} host_state_t;
endpackage

// File: design/tft_port_if.sv
`timescale 1ns/100ps
interface tft_port_if
	import tft_port_pkg::*;
;
	logic [CTL_W-1:0] dev_ctl_o;
	logic dev_ctl_oe;
	logic [DATA_W-1:0] dev_data_o;
	logic [DATA_W-1:0] dev_data_oe;
	logic [CTL_W-1:0] host_ctl_o;
	logic host_ctl_oe;
	logic [DATA_W-1:0] host_data_o;
	logic [DATA_W-1:0] host_data_oe;
	logic [CTL_W-1:0] ctl;
	logic [DATA_W-1:0] host_data;

	// Undriven lines float high through the board pull-ups.
	assign ctl = dev_ctl_oe ? dev_ctl_o : (host_ctl_oe ? host_ctl_o : '1);
	assign host_data = (dev_data_oe & dev_data_o)
		| (~dev_data_oe & host_data_oe & host_data_o)
		| (~dev_data_oe & ~host_data_oe);

	modport device_end (
		output dev_ctl_o, dev_ctl_oe, dev_data_o, dev_data_oe,
		input ctl, host_data
	);
	modport host_end (
		output host_ctl_o, host_ctl_oe, host_data_o, host_data_oe,
		input ctl, host_data
	);
endinterface

// File: design/tft_module_end.sv
`timescale 1ns/100ps
module tft_module_end
	import tft_port_pkg::*;
#(
	parameter int BUS_WIDTH = DEFAULT_BUS_WIDTH,
	parameter int INIT_CYCLES_P = INIT_CYCLES
) (
	// Clock, power-on reset and enable.
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// Host pins.
	tft_port_if.device_end port,
	// Board strap, low for separate read and write strobes.
	input wire logic mode_strap_in,
	// Controller side.
	input wire logic [DATA_W-1:0] rd_word_in,
	output logic word_valid_out,
	output logic word_is_cmd_out,
	output logic [DATA_W-1:0] word_out,
	output logic ctrl_reset_n_out,
	output logic init_busy_out,
	output logic frame_done_out,
	output logic enable_mode_out
);
	if (BUS_WIDTH != 8 && BUS_WIDTH != 16 && BUS_WIDTH != 18) begin : bad_width
		$error("Bus width must be 8, 16 or 18.");
	end
	if (INIT_CYCLES_P < 1 || INIT_CYCLES_P >= (1 << TIMER_W)) begin : bad_init
		$error("Init cycle count out of range.");
	end

	localparam logic [DATA_W-1:0] DATA_MASK = DATA_W'((1 << BUS_WIDTH) - 1);
	localparam int PIN_W = CTL_W + DATA_W + 1;

	logic [PIN_W-1:0] pin_meta;
	logic [PIN_W-1:0] pin_sync;
	logic [PIN_W-1:0] pin_prev;
	seq_state_t seq_state;
	logic [TIMER_W-1:0] timer;
	logic [INIT_IDX_W-1:0] init_idx;
	logic [1:0] strap_wait;
	logic mode_q;
	logic [PIX_CNT_W-1:0] pix_cnt;

	wire [PIN_W-1:0] pin_raw = {mode_strap_in, port.ctl, port.host_data};
	wire strap_s = pin_sync[PIN_W-1];
	wire [CTL_W-1:0] ctl_s = pin_sync[DATA_W +: CTL_W];
	wire [CTL_W-1:0] ctl_p = pin_prev[DATA_W +: CTL_W];
	wire [DATA_W-1:0] data_s = pin_sync[DATA_W-1:0];
	wire bus_open = seq_state == SEQ_DONE;
	wire sel_held = !ctl_s[CTL_CS] && !ctl_p[CTL_CS];
	// Write strobe rises, or enable falls with direction low.
	wire i_wr = !mode_q && !ctl_p[CTL_WR] && ctl_s[CTL_WR]; // [RULE9]
	wire m_wr = mode_q && ctl_p[CTL_RD] && !ctl_s[CTL_RD] && !ctl_p[CTL_WR]; // [RULE8]
	wire i_rd = !mode_q && !ctl_s[CTL_RD];
	wire m_rd = mode_q && ctl_s[CTL_RD] && ctl_s[CTL_WR];
	wire host_write = bus_open && sel_held && (i_wr || m_wr); // [RULE10]
	wire next_drive = bus_open && !ctl_s[CTL_CS] && (i_rd || m_rd);
	wire seq_push = seq_state == SEQ_LOAD;
	wire timer_done = timer == TIMER_W'(INIT_CYCLES_P - 1);
	wire is_data = ctl_s[CTL_CMD_DATA_SEL];
	wire last_pix = pix_cnt == PIX_CNT_W'(FRAME_PIXELS - 1);

	// Lines the sequencer drives while it owns the bus.
	assign port.dev_ctl_o = CTL_SEQ_LEVELS;

	always_ff @(posedge clk_sys_in) begin
		if (ce_in) begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// The strap is taken once, after the synchroniser has filled.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			strap_wait <= 2'h0;
			mode_q <= 1'b0;
		end else if (ce_in && strap_wait != 2'h3) begin
			strap_wait <= strap_wait + 2'h1;
			if (strap_wait == 2'h2) begin
				mode_q <= strap_s; // [RULE6]
			end
		end
	end

	// Only the power-on reset restarts the sequencer; the pin does not.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			seq_state <= SEQ_LOAD;
			timer <= '0;
			init_idx <= '0;
		end else if (ce_in) begin
			if (!timer_done) begin
				timer <= timer + 1'b1; // [RULE3]
			end
			unique case (seq_state)
				SEQ_LOAD: begin
					init_idx <= init_idx + 1'b1;
					if (init_idx == INIT_IDX_W'(INIT_LEN - 1)) begin
						seq_state <= SEQ_WAIT;
					end
				end
				SEQ_WAIT: begin
					if (timer_done) begin
						seq_state <= SEQ_DONE; // [RULE3]
					end
				end
				SEQ_DONE: begin
					seq_state <= SEQ_DONE;
				end
				default: begin
					seq_state <= SEQ_LOAD;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			word_valid_out <= 1'b0;
			word_is_cmd_out <= 1'b0;
			word_out <= '0;
		end else if (ce_in) begin
			word_valid_out <= seq_push || host_write;
			if (seq_push) begin
				{word_is_cmd_out, word_out} <= INIT_TABLE[init_idx]; // [RULE3]
			end else if (host_write) begin
				word_is_cmd_out <= !is_data;
				word_out <= data_s & DATA_MASK; // [RULE7]
			end
		end
	end

	// Counts pixels of one full image; a command restarts the count.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			pix_cnt <= '0;
			frame_done_out <= 1'b0;
		end else if (ce_in) begin
			frame_done_out <= host_write && is_data && last_pix; // [RULE11]
			if (host_write && !is_data) begin
				pix_cnt <= '0;
			end else if (host_write) begin
				pix_cnt <= last_pix ? '0 : pix_cnt + 1'b1; // [RULE11]
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			port.dev_ctl_oe <= 1'b1;
			port.dev_data_oe <= '0;
			port.dev_data_o <= '0;
			ctrl_reset_n_out <= 1'b0;
			init_busy_out <= 1'b1;
			enable_mode_out <= 1'b0;
		end else if (ce_in) begin
			port.dev_ctl_oe <= !bus_open; // [RULE1]
			port.dev_data_oe <= next_drive ? DATA_MASK : '0; // [RULE7]
			port.dev_data_o <= rd_word_in & DATA_MASK;
			// The reset pin reaches only the controller, so no re-init follows.
			ctrl_reset_n_out <= ctl_s[CTL_RST]; // [RULE4]
			init_busy_out <= !bus_open;
			enable_mode_out <= mode_q;
		end
	end
endmodule

// File: design/tft_host_end.sv
`timescale 1ns/100ps
module cmd_fifo
	import tft_port_pkg::*;
#(
	parameter int WIDTH = CMD_W,
	parameter int DEPTH = FIFO_DEPTH_DEF
) (
	// Clock, reset and enable.
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// Filling side.
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// Draining side.
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : bad_depth
		$error("Depth must be a power of two, at least 2.");
	end

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_idx;
	logic [AW-1:0] rd_idx;
	logic [AW:0] count;

	wire push = in_valid_in && in_ready_out;
	wire pop = out_valid_out && out_ready_in;
	wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

	assign out_data_out = mem[rd_idx];

	always_ff @(posedge clk_sys_in) begin
		if (ce_in && push) begin
			mem[wr_idx] <= in_data_in;
		end
	end

	// Flags are registered so both ready and valid leave from flip-flops.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			wr_idx <= '0;
			rd_idx <= '0;
			count <= '0;
			in_ready_out <= 1'b1;
			out_valid_out <= 1'b0;
		end else if (ce_in) begin
			if (push) begin
				wr_idx <= wr_idx + 1'b1;
			end
			if (pop) begin
				rd_idx <= rd_idx + 1'b1;
			end
			count <= next_count;
			in_ready_out <= next_count != (AW+1)'(DEPTH);
			out_valid_out <= next_count != '0;
		end
	end
endmodule

// Notes on behaviour
// RULE1: Host releases all bus lines during auto-init.
// RULE2: Host waits for select release or 1s.
// RULE3: Module self-initialises in about half second.
// RULE4: Reset pin reaches controller only, no re-init.
// RULE5: Host keeps module reset high at start-up.
// RULE6: Board strap picks strobe or enable protocol.
// RULE7: Bus is 8, 16 or 18 bits; rest float.
// RULE8: Enable mode: direction low writes, high reads.
// RULE9: Two strobe lines change meaning with protocol.
// RULE10: Chip select low throughout every access.
// RULE11: Frame buffer holds one 640x480 18bpp image.
// RULE12: Select line low for commands, high otherwise.
module tft_host_end
	import tft_port_pkg::*;
#(
	parameter int BUS_WIDTH = DEFAULT_BUS_WIDTH,
	parameter int WAIT_CYCLES_P = HOST_WAIT_CYCLES,
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
	// Clock, reset and enable.
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// Module pins.
	tft_port_if.host_end port,
	// Board strap, low for separate read and write strobes.
	input wire logic mode_strap_in,
	// Command queue.
	input wire logic cmd_valid_in,
	output logic cmd_ready_out,
	input wire logic cmd_read_in,
	input wire logic cmd_is_cmd_in,
	input wire logic [DATA_W-1:0] cmd_data_in,
	// Read answers.
	output logic resp_valid_out,
	output logic [DATA_W-1:0] resp_data_out,
	// Status and module reset request.
	input wire logic reset_req_in,
	output logic bus_ready_out
);
	if (BUS_WIDTH != 8 && BUS_WIDTH != 16 && BUS_WIDTH != 18) begin : bad_width
		$error("Bus width must be 8, 16 or 18.");
	end
	if (WAIT_CYCLES_P < 1 || WAIT_CYCLES_P >= (1 << TIMER_W)) begin : bad_wait
		$error("Wait cycle count out of range.");
	end

	localparam logic [DATA_W-1:0] DATA_MASK = DATA_W'((1 << BUS_WIDTH) - 1);
	localparam int SYNC_W = DATA_W + 2;

	// Control line levels for one bus phase.
	function automatic logic [CTL_W-1:0] ctl_levels(
		input logic enable_mode,
		input logic cs_n,
		input logic is_cmd,
		input logic rd,
		input logic strobe,
		input logic rst_req
	);
		logic [CTL_W-1:0] lv;
		lv[CTL_RST] = !rst_req;
		lv[CTL_CS] = cs_n;
		lv[CTL_CMD_DATA_SEL] = !is_cmd;
		if (enable_mode) begin
			lv[CTL_RD] = strobe;
			lv[CTL_WR] = rd;
		end else begin
			lv[CTL_RD] = !(strobe && rd);
			lv[CTL_WR] = !(strobe && !rd);
		end
		return lv;
	endfunction

	logic [SYNC_W-1:0] sync_meta;
	logic [SYNC_W-1:0] sync_pin;
	host_state_t state;
	logic [TIMER_W-1:0] timer;
	logic [PHASE_W-1:0] phase;
	logic cs_seen_low;
	logic mode_q;
	logic [CMD_W-1:0] req;
	logic fifo_valid;
	logic [CMD_W-1:0] fifo_data;

	wire [SYNC_W-1:0] sync_raw = {mode_strap_in, port.ctl[CTL_CS], port.host_data};
	wire strap_s = sync_pin[SYNC_W-1];
	wire cs_s = sync_pin[DATA_W];
	wire [DATA_W-1:0] data_s = sync_pin[DATA_W-1:0];
	wire [CMD_W-1:0] cmd_word = {cmd_read_in, cmd_is_cmd_in, cmd_data_in};
	wire fifo_take = state == H_IDLE;
	wire req_rd = req[CMD_READ_BIT];
	wire req_cmd = req[CMD_IS_CMD_BIT];
	wire new_rd = fifo_data[CMD_READ_BIT];
	wire new_cmd = fifo_data[CMD_IS_CMD_BIT];
	// The sequencer holds select low, so its release marks the end of init.
	wire init_end = (cs_seen_low && cs_s)
		|| timer == TIMER_W'(WAIT_CYCLES_P - 1); // [RULE2]
	wire [PHASE_W-1:0] phase_last = (state == H_SETUP) ? PHASE_W'(SETUP_CYC - 1)
		: (state == H_STROBE) ? PHASE_W'(STROBE_CYC - 1) : PHASE_W'(HOLD_CYC - 1);
	wire phase_done = phase == phase_last;

	cmd_fifo #(
		.WIDTH(CMD_W),
		.DEPTH(FIFO_DEPTH)
	) queue (
		.clk_sys_in(clk_sys_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.in_valid_in(cmd_valid_in),
		.in_ready_out(cmd_ready_out),
		.in_data_in(cmd_word),
		.out_valid_out(fifo_valid),
		.out_ready_in(fifo_take),
		.out_data_out(fifo_data)
	);

	always_ff @(posedge clk_sys_in) begin
		if (ce_in) begin
			sync_meta <= sync_raw;
			sync_pin <= sync_meta;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			state <= H_INIT;
			timer <= '0;
			cs_seen_low <= 1'b0;
			mode_q <= 1'b0;
			bus_ready_out <= 1'b0;
		end else if (ce_in) begin
			unique case (state)
				H_INIT: begin
					timer <= timer + 1'b1;
					if (!cs_s) begin
						cs_seen_low <= 1'b1;
					end
					if (init_end) begin
						state <= H_IDLE;
						mode_q <= strap_s; // [RULE6]
						bus_ready_out <= 1'b1;
					end
				end
				H_IDLE: begin
					if (fifo_valid) begin
						state <= H_SETUP;
					end
				end
				H_SETUP: begin
					if (phase_done) begin
						state <= H_STROBE;
					end
				end
				H_STROBE: begin
					if (phase_done) begin
						state <= H_HOLD;
					end
				end
				H_HOLD: begin
					if (phase_done) begin
						state <= H_IDLE;
					end
				end
				default: begin
					state <= H_INIT;
				end
			endcase
		end
	end

	// Phase counter restarts at the end of each phase and is held at zero in idle.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			phase <= '0;
		end else if (ce_in) begin
			phase <= (phase_done || state == H_IDLE) ? '0 : phase + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			req <= '0;
		end else if (ce_in && fifo_take && fifo_valid) begin
			req <= fifo_data;
		end
	end

	// The pins stay released until init has ended.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			port.host_ctl_oe <= 1'b0;
			port.host_ctl_o <= '1;
		end else if (ce_in) begin
			unique case (state)
				H_INIT: begin
					port.host_ctl_oe <= init_end; // [RULE1]
					port.host_ctl_o <= ctl_levels(strap_s, 1'b1, 1'b0, 1'b1, 1'b0,
						reset_req_in); // [RULE5]
				end
				H_IDLE: begin
					if (fifo_valid) begin
						port.host_ctl_o <= ctl_levels(mode_q, 1'b0, new_cmd, new_rd, 1'b0,
							reset_req_in); // [RULE12] [RULE10] [RULE8]
					end else begin
						port.host_ctl_o <= ctl_levels(mode_q, 1'b1, 1'b0, 1'b1, 1'b0,
							reset_req_in);
					end
				end
				H_SETUP: begin
					if (phase_done) begin
						port.host_ctl_o <= ctl_levels(mode_q, 1'b0, req_cmd, req_rd, 1'b1,
							reset_req_in); // [RULE9]
					end
				end
				H_STROBE: begin
					if (phase_done) begin
						port.host_ctl_o <= ctl_levels(mode_q, 1'b0, req_cmd, req_rd, 1'b0,
							reset_req_in); // [RULE10]
					end
				end
				H_HOLD: begin
					if (phase_done) begin
						port.host_ctl_o <= ctl_levels(mode_q, 1'b1, 1'b0, 1'b1, 1'b0,
							reset_req_in);
					end
				end
				default: begin
					port.host_ctl_oe <= 1'b0;
				end
			endcase
		end
	end

	// Unused data pins are never driven and so float.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			port.host_data_oe <= '0;
			port.host_data_o <= '0;
		end else if (ce_in) begin
			if (fifo_take && fifo_valid) begin
				port.host_data_o <= fifo_data[DATA_W-1:0] & DATA_MASK;
				port.host_data_oe <= new_rd ? '0 : DATA_MASK; // [RULE7]
			end else if (state == H_HOLD && phase_done) begin
				port.host_data_oe <= '0;
			end
		end
	end

	// Read data is taken in the last strobe cycle, after the module drives it.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			resp_valid_out <= 1'b0;
			resp_data_out <= '0;
		end else if (ce_in) begin
			resp_valid_out <= state == H_STROBE && phase_done && req_rd;
			if (state == H_STROBE && phase_done && req_rd) begin
				resp_data_out <= data_s & DATA_MASK;
			end
		end
	end
endmodule

// File: test/tft_port_properties.sv
`timescale 1ns/100ps
module tft_port_properties
	import tft_port_pkg::*;
#(
	parameter int BUS_WIDTH = DEFAULT_BUS_WIDTH
) (
	// Clock, reset and strap.
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic mode_strap_in,
	// Resolved control lines and output enables of both ends.
	input wire logic [CTL_W-1:0] ctl,
	input wire logic dev_ctl_oe,
	input wire logic [DATA_W-1:0] dev_data_oe,
	input wire logic host_ctl_oe,
	input wire logic [DATA_W-1:0] host_data_oe
);
	// Pins above the configured width must stay floating on both ends.
	localparam logic [DATA_W-1:0] UNUSED = ~({DATA_W{1'b1}} >> (DATA_W - BUS_WIDTH));
	wire host_on = host_ctl_oe && !dev_ctl_oe;
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (srst_in);
	chk_host_release: assert property (dev_ctl_oe |-> !host_ctl_oe && host_data_oe == '0)
		else $error("host drives the bus during auto init");
	chk_init_select: assert property (dev_ctl_oe |-> !ctl[CTL_CS])
		else $error("select not held low by the sequencer");
	chk_reset_idle: assert property ($rose(host_ctl_oe) |-> ctl[CTL_RST])
		else $error("host pulls module reset at takeover");
	chk_strobe_select: assert property (!mode_strap_in && host_on
		&& !(ctl[CTL_WR] && ctl[CTL_RD]) |-> !ctl[CTL_CS])
		else $error("strobe without chip select");
	chk_one_strobe: assert property (!mode_strap_in && host_on |-> ctl[CTL_WR] || ctl[CTL_RD])
		else $error("read and write strobes low together");
	chk_write_width: assert property (!mode_strap_in && host_on && $fell(ctl[CTL_WR])
		|-> !ctl[CTL_WR] [*8])
		else $error("write strobe shorter than eight cycles");
	chk_sel_stable: assert property (!mode_strap_in && host_on && $fell(ctl[CTL_WR])
		|=> $stable(ctl[CTL_CMD_DATA_SEL]) [*7])
		else $error("select line moved during strobe");
	chk_enable_write: assert property (mode_strap_in && host_on && $rose(ctl[CTL_RD])
		&& host_data_oe != '0 |-> !ctl[CTL_WR] && !ctl[CTL_CS])
		else $error("direction not low on a write");
	chk_enable_read: assert property (mode_strap_in && host_on && $rose(ctl[CTL_RD])
		&& host_data_oe == '0 |-> ctl[CTL_WR] && !ctl[CTL_CS])
		else $error("direction not high on a read");
	chk_width_float: assert property (((host_data_oe | dev_data_oe) & UNUSED) == '0)
		else $error("unused data pin driven");
	chk_no_contention: assert property ((host_data_oe & dev_data_oe) == '0)
		else $error("both ends drive the data bus");
endmodule

// File: test/tb_top.sv
`timescale 1ns/100ps
module tb_top
	import tft_port_pkg::*;
;
	// Short counts keep the run small; expectations follow from these values.
	localparam int BW = 16;
	localparam int INIT_P = 60;
	localparam int WAIT_P = 200;
	localparam logic [DATA_W-1:0] MASK = {DATA_W{1'b1}} >> (DATA_W - BW);
	logic clk_sys_in = 1'b0;
	logic srst_in = 1'b1;
	logic mode_strap = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_read = 1'b0;
	logic cmd_is_cmd = 1'b0;
	logic [DATA_W-1:0] cmd_data = '0;
	logic [DATA_W-1:0] rd_word = '0;
	logic reset_req = 1'b0;
	logic word_valid, word_is_cmd, ctrl_reset_n, init_busy, frame_done, enable_mode;
	logic cmd_ready, resp_valid, bus_ready;
	logic [DATA_W-1:0] word, resp_data;
	int failures = 0;
	int samples_checked = 0;
	int frame_pulses = 0;
	int seed = 32'h2843;
	logic [DATA_W:0] got[$];
	logic [DATA_W:0] exp[$];

	always #(CLK_PERIOD_NS / 2) clk_sys_in = ~clk_sys_in;

	tft_port_if tft_port_if_inst ();
	tft_module_end #(.BUS_WIDTH(BW), .INIT_CYCLES_P(INIT_P)) tft_module_end_inst (
		.clk_sys_in(clk_sys_in), .srst_in(srst_in), .ce_in(1'b1), .port(tft_port_if_inst),
		.mode_strap_in(mode_strap), .rd_word_in(rd_word), .word_valid_out(word_valid),
		.word_is_cmd_out(word_is_cmd), .word_out(word), .ctrl_reset_n_out(ctrl_reset_n),
		.init_busy_out(init_busy), .frame_done_out(frame_done), .enable_mode_out(enable_mode));
	tft_host_end #(.BUS_WIDTH(BW), .WAIT_CYCLES_P(WAIT_P)) tft_host_end_inst (
		.clk_sys_in(clk_sys_in), .srst_in(srst_in), .ce_in(1'b1), .port(tft_port_if_inst),
		.mode_strap_in(mode_strap), .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready),
		.cmd_read_in(cmd_read), .cmd_is_cmd_in(cmd_is_cmd), .cmd_data_in(cmd_data),
		.resp_valid_out(resp_valid), .resp_data_out(resp_data), .reset_req_in(reset_req),
		.bus_ready_out(bus_ready));
	tft_port_properties #(.BUS_WIDTH(BW)) tft_port_properties_inst (
		.clk_sys_in(clk_sys_in), .srst_in(srst_in), .mode_strap_in(mode_strap),
		.ctl(tft_port_if_inst.ctl), .dev_ctl_oe(tft_port_if_inst.dev_ctl_oe),
		.dev_data_oe(tft_port_if_inst.dev_data_oe), .host_ctl_oe(tft_port_if_inst.host_ctl_oe),
		.host_data_oe(tft_port_if_inst.host_data_oe));

	always @(posedge clk_sys_in) begin
		if (word_valid === 1'b1) begin
			got.push_back({word_is_cmd, word});
		end
		if (!srst_in && frame_done !== 1'b0) begin
			frame_pulses++;
		end
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask

	task automatic chk_val(input string what, input logic [DATA_W:0] e, input logic [DATA_W:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk_flag(input string what, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %b seen %b", what, e, g);
		end
	endtask

	// Only the configured low bits reach the far end; the rest float.
	function automatic logic [DATA_W:0] expect_word(input logic c, input logic [DATA_W-1:0] d);
		return {c, d & MASK};
	endfunction

	// Leaves valid high so callers can queue back to back without a gap.
	task automatic push(input logic r, input logic c, input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		cmd_valid = 1'b1;
		cmd_read = r;
		cmd_is_cmd = c;
		cmd_data = d;
		while (cmd_ready !== 1'b1 && n < 2000) begin
			step(1);
			n++;
		end
		if (n >= 2000) begin
			failures++;
			$display("mismatch cmd_ready expected 1 seen %b", cmd_ready);
		end
		step(1);
		if (!r) begin
			exp.push_back(expect_word(c, d));
		end
	endtask

	task automatic do_reset(input logic m);
		srst_in = 1'b1;
		mode_strap = m;
		got.delete();
		exp.delete();
		for (int i = 0; i < INIT_LEN; i++) begin
			exp.push_back(INIT_TABLE[i]);
		end
		step(4);
		srst_in = 1'b0;
	endtask

	task automatic wait_words(input int lim);
		int n;
		n = 0;
		while (got.size() < exp.size() && n < lim) begin
			step(1);
			n++;
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		int n;
		logic [DATA_W-1:0] d;
		for (int m = 0; m < 2; m++) begin
			do_reset(m[0]);
			// Upper random bits exercise the floating pins above the bus width.
			for (int i = 0; i < FIFO_DEPTH_DEF; i++) begin
				d = DATA_W'($random(seed));
				push(1'b0, i[0] ^ m[0], d);
			end
			chk_flag("cmd_ready_full", 1'b0, cmd_ready);
			cmd_valid = 1'b0;
			chk_flag("init_busy", 1'b1, init_busy);
			chk_flag("bus_ready_early", 1'b0, bus_ready);
			n = 0;
			while (bus_ready !== 1'b1 && n < WAIT_P + 50) begin
				step(1);
				n++;
			end
			chk_flag("bus_ready_by_select", 1'b1, n < WAIT_P - 100);
			chk_flag("init_done", 1'b0, init_busy);
			wait_words(400);
			chk_val("word_count", 19'(exp.size()), 19'(got.size()));
			foreach (exp[i]) chk_val("word", exp[i], got[i]);
			for (int k = 0; k < 3; k++) begin
				rd_word = (k == 0) ? 18'h3ffff : DATA_W'($random(seed));
				push(1'b1, 1'b0, '0);
				cmd_valid = 1'b0;
				n = 0;
				while (resp_valid !== 1'b1 && n < 100) begin
					step(1);
					n++;
				end
				chk_flag("resp_valid", 1'b1, resp_valid);
				chk_val("read_data", expect_word(1'b0, rd_word), {1'b0, resp_data});
			end
			chk_flag("strap_mode", m[0], enable_mode);
			reset_req = 1'b1;
			step(30);
			chk_flag("ctrl_reset_n", 1'b0, ctrl_reset_n);
			chk_flag("no_reinit", 1'b0, init_busy);
			reset_req = 1'b0;
			step(30);
			chk_flag("ctrl_reset_n_release", 1'b1, ctrl_reset_n);
			d = DATA_W'($random(seed));
			push(1'b0, 1'b1, d);
			cmd_valid = 1'b0;
			wait_words(100);
			step(10);
			chk_val("word_count", 19'(exp.size()), 19'(got.size()));
			chk_val("host_init_word", exp[$], got[$]);
		end
		// Far fewer pixels than one full image are sent, so no frame end may show.
		chk_flag("frame_done_idle", 1'b0, frame_pulses != 0);
		complete_run();
	end

	// About nine times the expected run length, so only a real hang reaches it.
	initial begin
		repeat (6000) @(posedge clk_sys_in);
		failures++;
		complete_run();
	end
endmodule
